// ===== core/plc_pkg.sv
// shared constants for the loop configuration register bank
package plc_pkg;
  // register port widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [9:0] OFS_ZERO_RES = 10'h01d;
  localparam logic [9:0] OFS_PUMP_CUR = 10'h0f0;
  localparam logic [9:0] OFS_FB_DIV = 10'h0f1;
  localparam logic [9:0] OFS_CTRL = 10'h0f2;
  // reset values
  localparam logic [7:0] RST_ZERO_RES = 8'h00;
  localparam logic [7:0] RST_PUMP_CUR = 8'h00;
  localparam logic [7:0] RST_FB_DIV = 8'h07;
  localparam logic [7:0] RST_CTRL = 8'h0b;
  // field positions
  localparam int ZR_CODE_MSB = 3;
  localparam int FB_SWALLOW_LSB = 6;
  localparam int FB_MAIN_MSB = 5;
  localparam int CTRL_LD_PD_BIT = 7;
  localparam int CTRL_DBL_BIT = 5;
  localparam int CTRL_ABL_SW_BIT = 4;
  localparam int CTRL_ABL_LSB = 2;
  localparam int CTRL_PMODE_LSB = 0;
  // zero resistor codes and one-hot select positions
  localparam logic [3:0] ZR_CODE_EXT = 4'h8;
  localparam int ZR_SEL_883K = 0;
  localparam int ZR_SEL_677K = 1;
  localparam int ZR_SEL_341K = 2;
  localparam int ZR_SEL_135K = 3;
  localparam int ZR_SEL_10K = 4;
  localparam int ZR_SEL_EXT = 5;
  localparam int ZR_SEL_W = 6;
  // feedback divider legality limits
  localparam logic [5:0] FB_MAIN_MIN = 6'h04;
  localparam logic [5:0] FB_MAIN_MID_HI = 6'h06;
  localparam logic [5:0] FB_MAIN_FULL = 6'h07;
  localparam logic [1:0] FB_SWALLOW_MAX_LO = 2'h1;
  localparam logic [1:0] FB_SWALLOW_MAX_MID = 2'h2;
  // antibacklash period and charge pump mode encodings
  typedef enum logic [1:0] {ABL_MIN, ABL_LOW, ABL_HIGH, ABL_MAX} plc_abl_e;
  typedef enum logic [1:0] {PM_TRISTATE, PM_UP, PM_DOWN, PM_NORMAL} plc_pm_e;
endpackage

// ===== core/plc_zero_res_dec.sv
`timescale 1ns/1ps
`default_nettype none
// turns the zero resistor code into a registered one-hot switch select
module plc_zero_res_dec
  import plc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // stored code
  input wire logic [3:0] code_in,
  // resistor select
  output logic [ZR_SEL_W-1:0] sel_out
);
  logic [ZR_SEL_W-1:0] next_sel; // decoded select

  // decode; codes above the external one close no switch
  always_comb begin
    next_sel = '0;
    case (code_in)
      4'h0: next_sel[ZR_SEL_883K] = 1'b1;
      4'h1: next_sel[ZR_SEL_677K] = 1'b1;
      4'h2: next_sel[ZR_SEL_341K] = 1'b1;
      4'h3: next_sel[ZR_SEL_135K] = 1'b1;
      4'h4, 4'h5, 4'h6, 4'h7: next_sel[ZR_SEL_10K] = 1'b1;
      ZR_CODE_EXT: next_sel[ZR_SEL_EXT] = 1'b1;
      default: next_sel = '0;
    endcase
  end

  // register the select
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sel_out <= '0;
    end else begin
      sel_out <= next_sel;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_zr_10k;
    (code_in[3:2] == 2'b01) |=> (sel_out == 6'h10);
  endproperty
  a_zr_10k: assert property (p_zr_10k)
    else $error("10k code did not select the 10k switch");

  property p_zr_ext;
    (code_in == ZR_CODE_EXT) |=> (sel_out == 6'h20);
  endproperty
  a_zr_ext: assert property (p_zr_ext)
    else $error("external code did not select external resistor");
endmodule
`default_nettype wire

// ===== core/plc_abl_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// antibacklash software control bit, stored field and effective period
module plc_abl_ctrl
  import plc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control register write
  input wire logic ctrl_wr_in,
  input wire logic sw_wr_in,
  input wire logic [1:0] field_wr_in,
  // state
  output logic sw_out,
  output logic [1:0] field_out,
  output logic [1:0] period_out
);
  logic next_sw; // next software control bit
  logic [1:0] next_field; // next stored field
  logic [1:0] next_period; // next effective period

  // write handling and period selection
  always_comb begin
    next_sw = sw_out;
    next_field = field_out;
    if (ctrl_wr_in) begin
      next_sw = sw_wr_in;
      if (sw_wr_in && !sw_out) begin
        next_field = ABL_MIN; // arming clears the field
      end else if (sw_wr_in) begin
        next_field = field_wr_in;
      end
    end
    // automatic mode forces the high period
    next_period = sw_out ? field_out : ABL_HIGH;
  end

  // register state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sw_out <= RST_CTRL[CTRL_ABL_SW_BIT];
      field_out <= RST_CTRL[CTRL_ABL_LSB +: 2];
      period_out <= ABL_HIGH;
    end else begin
      sw_out <= next_sw;
      field_out <= next_field;
      period_out <= next_period;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_auto_high;
    !sw_out |=> (period_out == ABL_HIGH);
  endproperty
  a_auto_high: assert property (p_auto_high)
    else $error("automatic mode did not give the high period");

  property p_arm_clear;
    (ctrl_wr_in && sw_wr_in && !sw_out) |=> (sw_out && field_out == ABL_MIN);
  endproperty
  a_arm_clear: assert property (p_arm_clear)
    else $error("arming software control did not clear the field");

  property p_sw_period;
    sw_out |=> (period_out == $past(field_out));
  endproperty
  a_sw_period: assert property (p_sw_period)
    else $error("software period does not follow the field");
endmodule
`default_nettype wire

// ===== core/plc_loop_cfg.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - zero resistor code picks resistor or external
// - eight-bit field sets synth pump current
// - divider is four main plus swallow
// - control bit 7 powers down lock detector
// - control bit 5 enables reference doubler
// - bit 4 clear forces high antibacklash
// - setting bit 4 clears antibacklash field
// - field selects min, low, high, max
// - pump mode field, normal after reset
// - zero resistor upper nibble reserved
module plc_loop_cfg
  import plc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register access port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // input cleanup loop filter
  output logic [ZR_SEL_W-1:0] filter_zero_resistor_sel_out,
  // output synth loop charge pump
  output logic [7:0] pump_current_out,
  output logic [1:0] pump_mode_out,
  // output synth loop feedback divider
  output logic [1:0] fb_swallow_out,
  output logic [5:0] fb_main_out,
  output logic [7:0] fb_div_out,
  output logic fb_div_legal_out,
  // output synth loop control
  output logic lock_det_pd_out,
  output logic ref_doubler_out,
  output logic [1:0] abl_period_out
);
  // address decode strobes
  logic wr_zr; // write to zero resistor register
  logic wr_pump; // write to pump current register
  logic wr_fb; // write to feedback divider register
  logic wr_ctrl; // write to control register

  // stored register state
  logic [3:0] zr_code; // zero resistor code
  logic [3:0] next_zr_code;
  logic [7:0] next_pump;
  logic [7:0] next_fb;
  logic [7:0] fb_reg; // swallow and main counts as written
  logic next_ld_pd;
  logic next_dbl;
  logic [1:0] next_pmode;

  // derived divider outputs
  logic [7:0] next_fb_div;
  logic next_legal;

  // readback path
  logic [DATA_W-1:0] next_rdata;
  logic next_rvalid;

  // antibacklash state from the submodule
  logic abl_sw; // software control bit
  logic [1:0] abl_field; // stored antibacklash field

  // decode the register address for writes
  always_comb begin
    wr_zr = reg_wr_in && (reg_addr_in == OFS_ZERO_RES);
    wr_pump = reg_wr_in && (reg_addr_in == OFS_PUMP_CUR);
    wr_fb = reg_wr_in && (reg_addr_in == OFS_FB_DIV);
    wr_ctrl = reg_wr_in && (reg_addr_in == OFS_CTRL);
  end

  // next values of the writable fields
  always_comb begin
    next_zr_code = zr_code;
    next_pump = pump_current_out;
    next_fb = fb_reg;
    next_ld_pd = lock_det_pd_out;
    next_dbl = ref_doubler_out;
    next_pmode = pump_mode_out;
    if (wr_zr) begin
      // upper nibble is dropped on write
      next_zr_code = reg_wdata_in[ZR_CODE_MSB:0];
    end
    if (wr_pump) begin
      next_pump = reg_wdata_in;
    end
    if (wr_fb) begin
      next_fb = reg_wdata_in;
    end
    if (wr_ctrl) begin
      next_ld_pd = reg_wdata_in[CTRL_LD_PD_BIT];
      // bit 6 has no storage
      next_dbl = reg_wdata_in[CTRL_DBL_BIT];
      next_pmode = reg_wdata_in[CTRL_PMODE_LSB +: 2];
    end
  end

  // register the writable fields
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      zr_code <= RST_ZERO_RES[ZR_CODE_MSB:0];
      pump_current_out <= RST_PUMP_CUR;
      fb_reg <= RST_FB_DIV;
      lock_det_pd_out <= RST_CTRL[CTRL_LD_PD_BIT];
      ref_doubler_out <= RST_CTRL[CTRL_DBL_BIT];
      pump_mode_out <= RST_CTRL[CTRL_PMODE_LSB +: 2];
    end else begin
      zr_code <= next_zr_code;
      pump_current_out <= next_pump;
      fb_reg <= next_fb;
      lock_det_pd_out <= next_ld_pd;
      ref_doubler_out <= next_dbl;
      pump_mode_out <= next_pmode;
    end
  end

  // divider value and legality of the stored counts
  always_comb begin
    // division is four times main plus swallow
    next_fb_div = {fb_reg[FB_MAIN_MSB:0], 2'b00}
                + {6'h00, fb_reg[FB_SWALLOW_LSB +: 2]};
    // flag counts outside the allowed table
    if (fb_reg[FB_MAIN_MSB:0] >= FB_MAIN_FULL) begin
      next_legal = 1'b1;
    end else if (fb_reg[FB_MAIN_MSB:0] > FB_MAIN_MIN) begin
      next_legal = (fb_reg[FB_SWALLOW_LSB +: 2] <= FB_SWALLOW_MAX_MID);
    end else if (fb_reg[FB_MAIN_MSB:0] == FB_MAIN_MIN) begin
      next_legal = (fb_reg[FB_SWALLOW_LSB +: 2] <= FB_SWALLOW_MAX_LO);
    end else begin
      next_legal = 1'b0;
    end
  end

  // register the divider outputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fb_swallow_out <= RST_FB_DIV[FB_SWALLOW_LSB +: 2];
      fb_main_out <= RST_FB_DIV[FB_MAIN_MSB:0];
      fb_div_out <= {RST_FB_DIV[FB_MAIN_MSB:0], 2'b00};
      fb_div_legal_out <= 1'b1;
    end else begin
      fb_swallow_out <= fb_reg[FB_SWALLOW_LSB +: 2];
      fb_main_out <= fb_reg[FB_MAIN_MSB:0];
      fb_div_out <= next_fb_div;
      fb_div_legal_out <= next_legal;
    end
  end

  // readback mux; reserved bits read as zero
  always_comb begin
    next_rdata = '0;
    next_rvalid = reg_rd_in;
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_ZERO_RES: next_rdata = {4'h0, zr_code};
        OFS_PUMP_CUR: next_rdata = pump_current_out;
        OFS_FB_DIV: next_rdata = fb_reg;
        OFS_CTRL: begin
          // bit 6 always reads zero
          next_rdata = {lock_det_pd_out, 1'b0, ref_doubler_out,
                        abl_sw, abl_field, pump_mode_out};
        end
        default: next_rdata = '0; // unmapped reads give zero
      endcase
    end
  end

  // register the read answer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rdata_out <= next_rdata;
      reg_rvalid_out <= next_rvalid;
    end
  end

  // zero resistor select decoder
  plc_zero_res_dec u_zero_res (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .code_in(zr_code),
    .sel_out(filter_zero_resistor_sel_out)
  );

  // antibacklash control and effective period
  plc_abl_ctrl u_abl (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ctrl_wr_in(wr_ctrl),
    .sw_wr_in(reg_wdata_in[CTRL_ABL_SW_BIT]),
    .field_wr_in(reg_wdata_in[CTRL_ABL_LSB +: 2]),
    .sw_out(abl_sw),
    .field_out(abl_field),
    .period_out(abl_period_out)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_pump_follow;
    wr_pump |=> (pump_current_out == $past(reg_wdata_in));
  endproperty
  a_pump_follow: assert property (p_pump_follow)
    else $error("pump current did not take the written value");

  property p_div_value;
    wr_fb |-> ##2 (fb_div_out ==
      {$past(reg_wdata_in[5:0], 2), 2'b00}
      + {6'h00, $past(reg_wdata_in[7:6], 2)});
  endproperty
  a_div_value: assert property (p_div_value)
    else $error("feedback division is not four main plus swallow");

  property p_div_illegal;
    (wr_fb && reg_wdata_in[5:0] < FB_MAIN_MIN) |-> ##2 !fb_div_legal_out;
  endproperty
  a_div_illegal: assert property (p_div_illegal)
    else $error("main count below four flagged legal");

  property p_lock_pd;
    wr_ctrl |=> (lock_det_pd_out == $past(reg_wdata_in[CTRL_LD_PD_BIT]));
  endproperty
  a_lock_pd: assert property (p_lock_pd)
    else $error("lock detector power-down does not follow bit 7");

  property p_doubler;
    wr_ctrl |=> (ref_doubler_out == $past(reg_wdata_in[CTRL_DBL_BIT]));
  endproperty
  a_doubler: assert property (p_doubler)
    else $error("reference doubler does not follow bit 5");

  property p_pmode_reset;
    $fell(rst_in) |-> (pump_mode_out == PM_NORMAL
                       && abl_period_out == ABL_HIGH);
  endproperty
  a_pmode_reset: assert property (p_pmode_reset)
    else $error("reset did not give normal pump and high period");

  property p_ctrl_rsvd;
    (reg_rd_in && reg_addr_in == OFS_CTRL) |=>
      (reg_rvalid_out && reg_rdata_out[6] == 1'b0);
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd)
    else $error("reserved control bit read nonzero");

  property p_zr_rsvd;
    (reg_rd_in && reg_addr_in == OFS_ZERO_RES) |=>
      (reg_rdata_out[7:4] == 4'h0);
  endproperty
  a_zr_rsvd: assert property (p_zr_rsvd)
    else $error("zero resistor upper nibble read nonzero");

  c_arm_sw: cover property (wr_ctrl && reg_wdata_in[CTRL_ABL_SW_BIT]
                            && !abl_sw);
  c_fb_max: cover property (wr_fb && reg_wdata_in == 8'hff);
  c_pump_up: cover property (wr_ctrl && reg_wdata_in[1:0] == PM_UP);
endmodule
`default_nettype wire

// ===== sim/plc_loop_cfg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// one comparison, counted, with a report line on mismatch
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end \
end
module plc_loop_cfg_tb_top
  import plc_pkg::*;
;
  // clock and reset
  logic clk_in;
  logic rst_in;
  // register access port
  logic [ADDR_W-1:0] reg_addr_in;
  logic reg_wr_in;
  logic [DATA_W-1:0] reg_wdata_in;
  logic reg_rd_in;
  logic [DATA_W-1:0] reg_rdata_out;
  logic reg_rvalid_out;
  // loop configuration outputs
  logic [ZR_SEL_W-1:0] filter_zero_resistor_sel_out;
  logic [7:0] pump_current_out;
  logic [1:0] pump_mode_out;
  logic [1:0] fb_swallow_out;
  logic [5:0] fb_main_out;
  logic [7:0] fb_div_out;
  logic fb_div_legal_out;
  logic lock_det_pd_out;
  logic ref_doubler_out;
  logic [1:0] abl_period_out;
  // bookkeeping
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] d;
  // divider settings: edges of the main-dependent swallow limits
  logic [7:0] fb_tab [9] = '{8'h04, 8'h44, 8'h84, 8'h85, 8'hc5, 8'h86,
    8'hc6, 8'hff, 8'h03};
  // control writes, expected readback and effective period
  logic [7:0] ab_w [6] = '{8'h1f, 8'h17, 8'h1b, 8'h1f, 8'h0f, 8'h1b};
  logic [7:0] ab_r [6] = '{8'h13, 8'h17, 8'h1b, 8'h1f, 8'h0f, 8'h13};
  logic [1:0] ab_p [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h0};

  // device under test
  plc_loop_cfg u_plc_loop_cfg (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out),
    .filter_zero_resistor_sel_out(filter_zero_resistor_sel_out),
    .pump_current_out(pump_current_out),
    .pump_mode_out(pump_mode_out),
    .fb_swallow_out(fb_swallow_out),
    .fb_main_out(fb_main_out),
    .fb_div_out(fb_div_out),
    .fb_div_legal_out(fb_div_legal_out),
    .lock_det_pd_out(lock_det_pd_out),
    .ref_doubler_out(ref_doubler_out),
    .abl_period_out(abl_period_out)
  );

  // 4 ns clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // expected one-hot switch select for a zero resistor code
  function automatic logic [5:0] zr_exp(input logic [3:0] c);
    if (c < 4'h4) return 6'h01 << c;
    if (c < 4'h8) return 6'h10;
    if (c == 4'h8) return 6'h20;
    return 6'h00;
  endfunction

  // expected legality of a main and swallow pair
  function automatic logic fb_ok(input logic [5:0] m, input logic [1:0] s);
    if (m < 6'h04) return 1'b0;
    if (m == 6'h04) return s <= 2'h1;
    if (m < 6'h07) return s <= 2'h2;
    return 1'b1;
  endfunction

  // one write, returning once all outputs have settled
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    @(negedge clk_in);
  endtask

  // one read, answer checked in its single valid cycle
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    `CHK("rvalid", 1'b1, reg_rvalid_out)
    `CHK("rdata", e, reg_rdata_out)
  endtask

  // counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard: the sequence needs well under 1000 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  // main sequence
  initial begin
    rst_in = 1'b1;
    reg_addr_in = '0;
    reg_wr_in = 1'b0;
    reg_wdata_in = '0;
    reg_rd_in = 1'b0;
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    // defaults after reset
    rd(OFS_CTRL, 8'h0b);
    rd(OFS_FB_DIV, 8'h07);
    rd(OFS_PUMP_CUR, 8'h00);
    rd(OFS_ZERO_RES, 8'h00);
    `CHK("abl_rst", 2'h2, abl_period_out)
    `CHK("pm_rst", 2'h3, pump_mode_out)
    `CHK("div_rst", 8'h1c, fb_div_out)
    `CHK("zr_rst", 6'h01, filter_zero_resistor_sel_out)
    // every zero resistor code, upper nibble written high
    for (int i = 0; i < 16; i++) begin
      wr(OFS_ZERO_RES, {4'hf, i[3:0]});
      `CHK("zr_sel", zr_exp(i[3:0]), filter_zero_resistor_sel_out)
      rd(OFS_ZERO_RES, {4'h0, i[3:0]});
    end
    // pump current straight through
    wr(OFS_PUMP_CUR, 8'ha5);
    `CHK("pump_cur", 8'ha5, pump_current_out)
    rd(OFS_PUMP_CUR, 8'ha5);
    // divider counts and their legality edges
    for (int i = 0; i < 9; i++) begin
      d = fb_tab[i];
      wr(OFS_FB_DIV, d);
      `CHK("fb_main", d[5:0], fb_main_out)
      `CHK("fb_swallow", d[7:6], fb_swallow_out)
      `CHK("fb_div", {d[5:0], 2'b00} + 8'(d[7:6]), fb_div_out)
      `CHK("fb_legal", fb_ok(d[5:0], d[7:6]), fb_div_legal_out)
      rd(OFS_FB_DIV, d);
    end
    // pump modes, detector and doubler, with period held high
    for (int i = 0; i < 4; i++) begin
      // reserved bit 6 is always written as zero
      d = {i[0], 1'b0, i[1], 1'b0, 2'b11, i[1:0]};
      wr(OFS_CTRL, d);
      `CHK("pmode", i[1:0], pump_mode_out)
      `CHK("ld_pd", i[0], lock_det_pd_out)
      `CHK("dbl", i[1], ref_doubler_out)
      `CHK("abl_auto", 2'h2, abl_period_out)
      rd(OFS_CTRL, {i[0], 1'b0, i[1], 3'b010, i[1:0]});
    end
    // arming, every period, disarm and rearm
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CTRL, ab_w[i]);
      `CHK("abl_period", ab_p[i], abl_period_out)
      rd(OFS_CTRL, ab_r[i]);
    end
    // unmapped place: write ignored, read answers zero
    wr(10'h0f3, 8'hff);
    rd(10'h0f3, 8'h00);
    rd(OFS_PUMP_CUR, 8'ha5);
    // read and write in one cycle: old value returned
    @(negedge clk_in);
    reg_addr_in = OFS_PUMP_CUR;
    reg_wdata_in = 8'h3c;
    reg_wr_in = 1'b1;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    `CHK("rw_old", 8'ha5, reg_rdata_out)
    rd(OFS_PUMP_CUR, 8'h3c);
    // second reset in mid-run
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    rd(OFS_CTRL, 8'h0b);
    `CHK("abl_rst2", 2'h2, abl_period_out)
    print_verdict();
  end
endmodule
`default_nettype wire
